//--- sim/felcu_flash_model.sv
// Behavioural flash array: erase engine and nonvolatile lock store.
`timescale 1ns/1ps
`default_nettype none
module felcu_flash_model #(
  parameter int NB = 15
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Erase engine.
  input wire logic erase_start,
  input wire logic slow,
  output logic erase_done,
  // Lock bit store.
  input wire logic nv_wr,
  input wire logic [3:0] nv_idx,
  input wire logic nv_val,
  output logic nv_done,
  output logic [NB-1:0] nv_lock
);
  int ecnt;
  int ncnt;
  // survives any reset
  // Lock bits power up unprotected and are never reset.
  initial
  begin
    nv_lock = '1;
    nv_done = 1'b0;
    ncnt = 0;
  end
  // whole block erase
  // Each erase takes a short or long time, then pulses done.
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ecnt <= 0;
      erase_done <= 1'b0;
    end
    else
    begin
      erase_done <= (ecnt == 1);
      if (erase_start)
        ecnt <= slow ? 20 : 3;
      else if (ecnt > 0)
        ecnt <= ecnt - 1;
    end
  // store write
  // A store write lands after three cycles, with done.
  always @(posedge clk)
  begin
    nv_done <= 1'b0;
    if (!nrst || !nv_wr || nv_done)
      ncnt <= 0;
    else if (ncnt == 2)
    begin
      nv_lock[nv_idx] <= nv_val;
      nv_done <= 1'b1;
    end
    else
      ncnt <= ncnt + 1;
  end
endmodule
`default_nettype wire

//--- sim/felcu_top_asserts.sv
// Port checker for the flash erase and lock command unit.
`timescale 1ns/1ps
`default_nettype none
module felcu_top_asserts #(
  parameter int NUM_BLOCKS = 15
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Processor side.
  input wire felcu_pkg::felcu_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic protection_override,
  // Erase engine and lock store.
  input wire logic erase_start,
  input wire logic [3:0] erase_blk,
  input wire logic erase_done,
  input wire logic [NUM_BLOCKS-1:0] nv_lock,
  input wire logic nv_wr,
  input wire logic [3:0] nv_idx,
  input wire logic nv_val,
  input wire logic nv_done,
  // Status.
  input wire logic flash_ready_flag,
  input wire logic [15:0] flash_status_two
);
  import felcu_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] err;
  // Error field of the second status word.
  assign err = flash_status_two[12:10];
  // A command word written while the ready flag is high, in idle or in confirm.
  sequence s_cmd(w);
    flash_ready_flag && bus_req.wr && bus_req.wdata == w;
  endsequence
  // Status command, then a read two cycles later.
  sequence s_stat_rd;
    s_cmd(16'h7070) ##2 bus_req.rd;
  endsequence
  // Lock command, then a read of block two's last even word.
  sequence s_lock_rd;
    s_cmd(16'h7171) ##2 bus_req.rd && bus_req.addr == 20'h07ffe;
  endsequence
  a_read_answer: assert property (bus_req.rd |=> bus_rvalid)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (!bus_req.rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_status_read: assert property (s_stat_rd |=>
    bus_rdata == $past(flash_status_two))
    else $error("status read wrong");
  a_lock_word: assert property (s_lock_rd |=>
    bus_rdata[1] == $past(nv_lock[2]) && bus_rdata[9] == bus_rdata[1])
    else $error("lock word wrong");
  a_clear_bits: assert property (s_cmd(16'h5050) |=> err == 3'h0)
    else $error("error bits not cleared");
  a_busy_start: assert property (erase_start |-> !flash_ready_flag)
    else $error("erase started while ready");
  a_err_blocks: assert property (
    $past(flash_ready_flag && err != 3'h0) |-> !erase_start && !nv_wr)
    else $error("operation started with error set");
  a_lock_guard: assert property (
    erase_done && !protection_override |-> nv_lock[erase_blk])
    else $error("protected block erased");
  a_unlock_path: assert property ($rose(nv_wr) && nv_val |->
    protection_override && (erase_done || $past(erase_done)))
    else $error("lock bit raised outside erase");
  a_lock_prog: assert property ($rose(nv_wr) && !nv_val |->
    $past(bus_req.wr && bus_req.wdata == 16'hd0d0))
    else $error("lock bit cleared without confirm");
  a_nv_hold: assert property (nv_wr && !nv_done |=>
    (nv_wr || nv_done) && $stable(nv_idx) && $stable(nv_val))
    else $error("store write dropped early");
endmodule
bind felcu_top felcu_top_asserts #(.NUM_BLOCKS(NUM_BLOCKS))
  i_felcu_top_asserts (
  .clk, .nrst, .bus_req, .bus_rdata, .bus_rvalid, .protection_override,
  .erase_start, .erase_blk, .erase_done, .nv_lock, .nv_wr, .nv_idx,
  .nv_val, .nv_done, .flash_ready_flag, .flash_status_two);
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking testbench for the flash erase and lock command unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import felcu_pkg::*;
  logic clk, nrst, protection_override, erase_fail, slow;
  felcu_bus_req_t bus_req;
  logic [15:0] bus_rdata, array_rdata, flash_status_two;
  logic bus_rvalid, erase_start, erase_done, nv_wr, nv_val, nv_done;
  logic flash_ready_flag;
  logic [3:0] erase_blk, nv_idx;
  logic [14:0] nv_lock;
  int fail_count, check_count, starts;
  felcu_top #(.NUM_BLOCKS(15)) i_felcu_top (.clk, .nrst, .bus_req,
    .bus_rdata, .bus_rvalid, .protection_override, .array_rdata,
    .erase_start, .erase_blk, .erase_done, .erase_fail, .nv_lock, .nv_wr,
    .nv_idx, .nv_val, .nv_done, .flash_ready_flag, .flash_status_two);
  felcu_flash_model #(.NB(15)) i_felcu_flash_model (.clk, .nrst,
    .erase_start, .slow, .erase_done, .nv_wr, .nv_idx, .nv_val, .nv_done,
    .nv_lock);
  // Array data is a fixed pattern of the address.
  assign array_rdata = bus_req.addr[15:0] ^ 16'h5a5a;
  // Clock at 125 MHz.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Count erase requests where they have settled.
  always @(negedge clk)
    if (erase_start === 1'b1)
      starts++;
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(negedge clk);
    bus_req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    bus_req = '0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [15:0] d);
    @(negedge clk);
    bus_req = '{1'b0, 1'b1, a, 16'h0};
    @(negedge clk);
    bus_req = '0;
    chk("rvalid", 16'h1, {15'h0, bus_rvalid});
    d = bus_rdata;
  endtask
  task automatic wait_rdy;
    int i;
    i = 0;
    repeat (2) @(negedge clk);
    while (flash_ready_flag !== 1'b1 && i < 1000)
    begin
      @(negedge clk);
      i++;
    end
    chk("ready", 16'h1, {15'h0, flash_ready_flag});
  endtask
  task automatic ers(input logic [19:0] a);
    wr(20'h0, 16'h2020);
    wr(a, 16'hd0d0);
    wait_rdy;
  endtask
  task automatic lkp(input logic [19:0] a);
    wr(20'h0, 16'h7777);
    wr(a, 16'hd0d0);
    wait_rdy;
  endtask
  task automatic t_lock(input logic [19:0] a, input logic b);
    logic [15:0] d;
    wr(20'h0, 16'h7171);
    rd(a, d);
    chk("lock", {14'h0, b, b}, {14'h0, d[9], d[1]});
  endtask
  task automatic t_status;
    logic [15:0] d;
    chk("status", 16'h0080, flash_status_two);
    wr(20'h0, 16'h7070);
    rd(20'h4, d);
    chk("status read", 16'h0080, d);
  endtask
  task automatic t_refuse;
    int s;
    s = starts;
    ers(20'h07ffe);
    chk("refuse", s[15:0], starts[15:0]);
    chk("erase err", 16'h1, {15'h0, flash_status_two[12]});
    ers(20'h05ffe);
    chk("err block", s[15:0], starts[15:0]);
    wr(20'h0, 16'h5050);
    chk("clear", 16'h0080, flash_status_two);
    ers(20'h05ffe);
    chk("erase", s[15:0] + 16'h1, starts[15:0]);
    chk("erase blk", 16'h1, {12'h0, erase_blk});
  endtask
  task automatic t_fail;
    erase_fail = 1'b1;
    ers(20'h05ffe);
    erase_fail = 1'b0;
    chk("fail", 16'h1, {15'h0, flash_status_two[12]});
    wr(20'h0, 16'h5050);
  endtask
  task automatic t_unlock;
    protection_override = 1'b1;
    ers(20'h07ffe);
    protection_override = 1'b0;
    chk("unlock idx", 16'h2, {12'h0, nv_idx});
    t_lock(20'h07ffe, 1'b1);
  endtask
  task automatic t_bulk;
    int s;
    lkp(20'h07ffe);
    s = starts;
    slow = 1'b1;
    wr(20'h0, 16'ha7a7);
    wr(20'h0, 16'hd0d0);
    chk("busy", 16'h0, {15'h0, flash_ready_flag});
    ers(20'h05ffe);
    slow = 1'b0;
    chk("bulk", s[15:0] + 16'he, starts[15:0]);
    t_lock(20'h07ffe, 1'b0);
  endtask
  task automatic t_array;
    logic [15:0] d;
    wr(20'h0, 16'hffff);
    rd(20'h01234, d);
    chk("array", 16'h1234 ^ 16'h5a5a, d);
  endtask
  task automatic t_keep;
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    t_lock(20'h07ffe, 1'b0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hang.
  initial
  begin
    #40000;
    fail_count++;
    results;
  end
  // Main sequence.
  initial
  begin
    nrst = 1'b0;
    bus_req = '0;
    protection_override = 1'b0;
    erase_fail = 1'b0;
    slow = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    t_status;
    t_lock(20'h07ffe, 1'b1);
    lkp(20'h07ffe);
    t_lock(20'h07ffe, 1'b0);
    t_refuse;
    t_fail;
    t_unlock;
    t_bulk;
    t_array;
    t_keep;
    results;
  end
endmodule
`default_nettype wire

//--- src/felcu_block_decode.sv
// Address to erase block decoder for the flash command unit.
`timescale 1ns/1ps
`default_nettype none
`include "felcu_params.svh"
module felcu_block_decode #(
  parameter int NUM_BLOCKS = `FELCU_NUM_BLOCKS
) (
  // Address in.
  input wire logic [19:0] addr,
  // Decoded block.
  output logic [3:0] blk_idx,
  output logic blk_hit,
  output logic last_even
);
  import felcu_pkg::*;

  logic [NUM_BLOCKS-1:0] hit;
  logic [NUM_BLOCKS-1:0] at_end;

  // Last byte address of block n.
  function automatic logic [19:0] blk_end(input int n);
    logic [19:0] e;
    case (n)
      0: e = `FELCU_BLK0_END;
      1: e = `FELCU_BLK1_END;
      2: e = `FELCU_BLK2_END;
      3: e = `FELCU_BLK3_END;
      default: e = 20'(`FELCU_BLK3_END + (n - 3) * `FELCU_BIG_BLK_SIZE);
    endcase
    return e;
  endfunction

  // [RQ13] one compare per block
  for (genvar i = 0; i < NUM_BLOCKS; i++)
  begin : g_blk
    localparam logic [19:0] LO =
      (i == 0) ? 20'h00000 : 20'(blk_end(i - 1) + 1);
    localparam logic [19:0] HI = blk_end(i);
    assign hit[i] = (addr >= LO) && (addr <= HI);
    assign at_end[i] = (addr == 20'(HI - 1));
  end

  // Blocks do not overlap, so at most one hit is set.
  always_comb
  begin
    blk_idx = 4'h0;
    blk_hit = 1'b0;
    last_even = 1'b0;
    for (int j = 0; j < NUM_BLOCKS; j++)
    begin
      if (hit[j])
      begin
        blk_idx = 4'(j);
        blk_hit = 1'b1;
        last_even = at_end[j];
      end
    end
  end
endmodule
`default_nettype wire

//--- src/felcu_params.svh
// Constants of the flash erase and lock command unit.
`ifndef FELCU_PARAMS_SVH
`define FELCU_PARAMS_SVH
// Command words written to any flash address, except a block or lock confirm, which goes to the block's last even address.
`define FELCU_CMD_READ_ARRAY 16'hffff
`define FELCU_CMD_BLOCK_ERASE 16'h2020
`define FELCU_CMD_BULK_ERASE 16'ha7a7
`define FELCU_CMD_READ_STATUS 16'h7070
`define FELCU_CMD_CLEAR_STATUS 16'h5050
`define FELCU_CMD_READ_LOCK 16'h7171
`define FELCU_CMD_LOCK_PROGRAM 16'h7777
`define FELCU_CMD_CONFIRM 16'hd0d0
// Field positions in the second status word.
`define FELCU_ST2_READY_BIT 7
`define FELCU_ST2_PROG_ERR1_BIT 10
`define FELCU_ST2_PROG_ERR2_BIT 11
`define FELCU_ST2_ERASE_ERR_BIT 12
// Field positions in the lock status word.
`define FELCU_LOCK_LOW_BIT 1
`define FELCU_LOCK_HIGH_BIT 9
// Block layout: four uneven low blocks, then equal large blocks.
`define FELCU_BLK0_END 20'h03fff
`define FELCU_BLK1_END 20'h05fff
`define FELCU_BLK2_END 20'h07fff
`define FELCU_BLK3_END 20'h0ffff
`define FELCU_BIG_BLK_SIZE 20'h10000
`define FELCU_NUM_BLOCKS 15
`endif

//--- src/felcu_pkg.sv
// Types shared by the flash erase and lock command unit.
package felcu_pkg;
  // One processor access to the flash address space.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [15:0] wdata;
  } felcu_bus_req_t;
  // What a read of the flash space returns.
  typedef enum logic [1:0] {
    FELCU_RD_ARRAY,
    FELCU_RD_STATUS,
    FELCU_RD_LOCK
  } felcu_rd_mode_t;
endpackage

//--- src/felcu_top.sv
// Command sequencer for flash erase, status and lock bit handling.
// How it works
// [RQ1] Erase command, confirm at block's last even address.
// [RQ2] Protected block erase refused unless override set.
// [RQ3] Ready flag low while erasing; erases refused.
// [RQ4] Bulk erase command, confirm anywhere, unprotected blocks.
// [RQ5] Status command makes next read return status.
// [RQ6] Clear command zeroes status bits ten to twelve.
// [RQ7] Error bits set block program and erase.
// [RQ8] Lock command makes block end read lock word.
// [RQ9] Lock word: bits one and nine, zero protected.
// [RQ10] Lock program sequence only way to protect.
// [RQ11] Unprotect only by override plus erase.
// [RQ12] Lock bits live in nonvolatile storage.
// [RQ13] Erase whole blocks: 16K,8K,8K,32K, then 64K.
// [RQ14] Read array command restores normal reads.
// [RQ15] Erase or lock commands ignored while busy.
`timescale 1ns/1ps
`default_nettype none
`include "felcu_params.svh"
module felcu_top #(
  parameter int NUM_BLOCKS = `FELCU_NUM_BLOCKS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Processor access to the flash space.
  input wire felcu_pkg::felcu_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  // Protection override control bit.
  input wire logic protection_override,
  // Flash array read data and erase engine.
  input wire logic [15:0] array_rdata,
  output logic erase_start,
  output logic [3:0] erase_blk,
  input wire logic erase_done,
  input wire logic erase_fail,
  // Nonvolatile lock bit store.
  input wire logic [NUM_BLOCKS-1:0] nv_lock,
  output logic nv_wr,
  output logic [3:0] nv_idx,
  output logic nv_val,
  input wire logic nv_done,
  // Status.
  output logic flash_ready_flag,
  output logic [15:0] flash_status_two
);
  import felcu_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CONFIRM,
    S_ERASE_ISSUE,
    S_ERASE_WAIT,
    S_UNLOCK_WAIT,
    S_LOCK_WAIT
  } felcu_state_t;

  typedef enum logic [1:0] {
    OP_ERASE,
    OP_BULK,
    OP_LOCK
  } felcu_op_t;

  felcu_state_t state_r;
  felcu_op_t op_r;
  felcu_rd_mode_t rd_mode_r;
  logic [3:0] cur_blk_r;
  logic bulk_r;
  logic prog_err1_r;
  logic prog_err2_r;
  logic erase_err_r;
  logic [3:0] dec_blk;
  logic dec_hit;
  logic dec_last_even;
  logic busy;
  logic any_err;
  logic wr_cmd;
  logic confirm_ok;
  logic blk_allowed;
  logic set_erase_err;
  logic set_prog_err1;
  logic set_prog_err2;
  logic clear_status;
  logic [15:0] lock_word;

  // Map the access address to a block.
  felcu_block_decode #(
    .NUM_BLOCKS(NUM_BLOCKS)
  ) u_decode (
    .addr(bus_req.addr),
    .blk_idx(dec_blk),
    .blk_hit(dec_hit),
    .last_even(dec_last_even)
  );

  // Sequencer is busy from confirm to end of erase or lock program.
  assign busy = (state_r != S_IDLE) && (state_r != S_CONFIRM);
  assign any_err = prog_err1_r | prog_err2_r | erase_err_r;
  // [RQ15] busy ignores new sequences
  // Writes are only decoded in idle or confirm, so a running job is safe.
  assign wr_cmd = bus_req.wr && (state_r == S_IDLE);
  assign clear_status = bus_req.wr && (state_r == S_IDLE) &&
                        (bus_req.wdata == `FELCU_CMD_CLEAR_STATUS);

  // [RQ2] override gate on lock
  assign blk_allowed = !nv_lock[cur_blk_r] ? protection_override : 1'b1;

  // [RQ1] confirm address check
  always_comb
  begin
    confirm_ok = 1'b0;
    if (bus_req.wr && (state_r == S_CONFIRM) &&
        (bus_req.wdata == `FELCU_CMD_CONFIRM))
    begin
      if (op_r == OP_BULK)
        confirm_ok = 1'b1;
      else
        confirm_ok = dec_hit && dec_last_even;
    end
  end

  // Error events raised by the sequencer.
  always_comb
  begin
    set_erase_err = 1'b0;
    set_prog_err1 = 1'b0;
    set_prog_err2 = 1'b0;
    if (bus_req.wr && (state_r == S_CONFIRM) && !confirm_ok)
    begin
      if (op_r == OP_LOCK)
        set_prog_err1 = 1'b1;
      else
        set_erase_err = 1'b1;
    end
    // [RQ2] protected block refused
    if ((state_r == S_ERASE_ISSUE) && !bulk_r && !blk_allowed)
      set_erase_err = 1'b1;
    if ((state_r == S_ERASE_WAIT) && erase_done && erase_fail)
      set_erase_err = 1'b1;
    if ((state_r == S_LOCK_WAIT) && nv_done && nv_lock[cur_blk_r])
      set_prog_err2 = 1'b1;
  end

  // Command sequencer.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= S_IDLE;
      op_r <= OP_ERASE;
      cur_blk_r <= 4'h0;
      bulk_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          // [RQ7] errors block new operations
          if (wr_cmd && !any_err)
          begin
            case (bus_req.wdata)
              `FELCU_CMD_BLOCK_ERASE:
              begin
                op_r <= OP_ERASE;
                state_r <= S_CONFIRM;
              end
              // [RQ4] bulk erase command
              `FELCU_CMD_BULK_ERASE:
              begin
                op_r <= OP_BULK;
                state_r <= S_CONFIRM;
              end
              // [RQ10] lock program command
              `FELCU_CMD_LOCK_PROGRAM:
              begin
                op_r <= OP_LOCK;
                state_r <= S_CONFIRM;
              end
              default:
              begin
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        S_CONFIRM:
        begin
          if (bus_req.wr)
          begin
            state_r <= S_IDLE;
            if (confirm_ok)
            begin
              bulk_r <= (op_r == OP_BULK);
              cur_blk_r <= (op_r == OP_BULK) ? 4'h0 : dec_blk;
              state_r <= (op_r == OP_LOCK) ? S_LOCK_WAIT : S_ERASE_ISSUE;
            end
          end
        end
        // [RQ13] one whole block per erase
        S_ERASE_ISSUE:
        begin
          if (blk_allowed)
            state_r <= S_ERASE_WAIT;
          else if (bulk_r && (cur_blk_r != 4'(NUM_BLOCKS - 1)))
            cur_blk_r <= cur_blk_r + 4'h1;
          else
            state_r <= S_IDLE;
        end
        S_ERASE_WAIT:
        begin
          if (erase_done)
          begin
            // [RQ11] erase with override unlocks
            if (!nv_lock[cur_blk_r] && !erase_fail)
              state_r <= S_UNLOCK_WAIT;
            else if (bulk_r && (cur_blk_r != 4'(NUM_BLOCKS - 1)))
            begin
              cur_blk_r <= cur_blk_r + 4'h1;
              state_r <= S_ERASE_ISSUE;
            end
            else
              state_r <= S_IDLE;
          end
        end
        S_UNLOCK_WAIT:
        begin
          if (nv_done)
          begin
            if (bulk_r && (cur_blk_r != 4'(NUM_BLOCKS - 1)))
            begin
              cur_blk_r <= cur_blk_r + 4'h1;
              state_r <= S_ERASE_ISSUE;
            end
            else
              state_r <= S_IDLE;
          end
        end
        S_LOCK_WAIT:
        begin
          if (nv_done)
            state_r <= S_IDLE;
        end
        default:
        begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Erase engine request, one cycle per allowed block.
  assign erase_start = (state_r == S_ERASE_ISSUE) && blk_allowed;
  assign erase_blk = cur_blk_r;

  // [RQ12] lock bits written to nonvolatile store
  assign nv_wr = ((state_r == S_LOCK_WAIT) || (state_r == S_UNLOCK_WAIT)) &&
                 !nv_done;
  assign nv_idx = cur_blk_r;
  assign nv_val = (state_r == S_UNLOCK_WAIT);

  // Error flags; a new error wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prog_err1_r <= 1'b0;
      prog_err2_r <= 1'b0;
      erase_err_r <= 1'b0;
    end
    else
    begin
      // [RQ6] clear status bits
      prog_err1_r <= set_prog_err1 | (prog_err1_r & !clear_status);
      prog_err2_r <= set_prog_err2 | (prog_err2_r & !clear_status);
      erase_err_r <= set_erase_err | (erase_err_r & !clear_status);
    end
  end

  // [RQ3] ready flag tracks busy
  assign flash_ready_flag = !busy;

  // Second status word.
  always_comb
  begin
    flash_status_two = 16'h0000;
    flash_status_two[`FELCU_ST2_READY_BIT] = !busy;
    flash_status_two[`FELCU_ST2_PROG_ERR1_BIT] = prog_err1_r;
    flash_status_two[`FELCU_ST2_PROG_ERR2_BIT] = prog_err2_r;
    flash_status_two[`FELCU_ST2_ERASE_ERR_BIT] = erase_err_r;
  end

  // [RQ9] lock word with two copies
  always_comb
  begin
    lock_word = 16'h0000;
    lock_word[`FELCU_LOCK_LOW_BIT] = nv_lock[dec_blk];
    lock_word[`FELCU_LOCK_HIGH_BIT] = nv_lock[dec_blk];
  end

  // Read mode follows the last mode command.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_mode_r <= FELCU_RD_ARRAY;
    else if (bus_req.wr && (state_r == S_IDLE))
    begin
      case (bus_req.wdata)
        // [RQ14] back to array reads
        `FELCU_CMD_READ_ARRAY: rd_mode_r <= FELCU_RD_ARRAY;
        // [RQ5] status read mode
        `FELCU_CMD_READ_STATUS: rd_mode_r <= FELCU_RD_STATUS;
        // [RQ8] lock read mode
        `FELCU_CMD_READ_LOCK: rd_mode_r <= FELCU_RD_LOCK;
        default: rd_mode_r <= rd_mode_r;
      endcase
    end
  end

  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_rdata <= 16'h0000;
      bus_rvalid <= 1'b0;
    end
    else
    begin
      bus_rvalid <= bus_req.rd;
      if (bus_req.rd)
      begin
        if (rd_mode_r == FELCU_RD_STATUS)
          bus_rdata <= flash_status_two;
        // [RQ8] lock word at block end
        else if ((rd_mode_r == FELCU_RD_LOCK) && dec_hit && dec_last_even)
          bus_rdata <= lock_word;
        else
          bus_rdata <= array_rdata;
      end
    end
  end
endmodule
`default_nettype wire
